//--- rtl/sfr_pkg.sv
// Shared constants, types and decoders of the serial fiber port router.
package sfr_pkg;

  // Receiver threshold comparators, thermometer coded.
  localparam int LVL_W     = 3;
  localparam int LVL_FLOOR = 0;
  localparam int LVL_RSV   = 1;
  localparam int LVL_HIGH  = 2;

  // Bar graph segments: green high, green low, yellow, red.
  localparam int BAR_W = 4;
  localparam logic [BAR_W-1:0] BAR_OFF   = 4'h0;
  localparam logic [BAR_W-1:0] BAR_VGOOD = 4'h7;
  localparam logic [BAR_W-1:0] BAR_GOOD  = 4'h6;
  localparam logic [BAR_W-1:0] BAR_CRIT  = 4'h4;
  localparam logic [BAR_W-1:0] BAR_ERR   = 4'h8;

  // Activity indicator stretch time.
  localparam int CLK_PERIOD_NS = 20;
  localparam int ACT_PULSE_NS  = 10_000_000;
  localparam int ACT_PULSE_CYC = ACT_PULSE_NS / CLK_PERIOD_NS;
  localparam int ACT_CNT_W     = 20;

  typedef enum logic [1:0] {
    Q_ERR,
    Q_CRIT,
    Q_GOOD,
    Q_VGOOD
  } sfr_qual_e;

  typedef struct packed {
    logic                 cfg_done;
    logic                 star;
    logic                 idle_light_off;
    logic                 red;
    logic                 bdis;
    logic                 use_b;
    logic                 cu_txd;
    logic                 a_tx;
    logic                 b_tx;
    logic                 bp_o;
    logic                 bp_oe;
    logic [BAR_W-1:0]     bar_a;
    logic [BAR_W-1:0]     bar_b;
    logic                 relay;
    logic                 led_tx;
    logic                 led_rx;
    logic [ACT_CNT_W-1:0] tx_cnt;
    logic [ACT_CNT_W-1:0] rx_cnt;
  } sfr_state_s;

  // Reset state: switches read as off, serial line at mark, optics dark.
  localparam sfr_state_s SFR_STATE_RST = '{cu_txd: 1'b1, default: '0};

  function automatic sfr_qual_e sfr_quality(input logic [LVL_W-1:0] lvl);
    if (!lvl[LVL_FLOOR])     return Q_ERR;
    else if (!lvl[LVL_RSV])  return Q_CRIT;
    else if (!lvl[LVL_HIGH]) return Q_GOOD;
    else                     return Q_VGOOD;
  endfunction : sfr_quality

endpackage : sfr_pkg

//--- rtl/sfr_router.sv
// Routing, idle level and diagnostic logic of the serial fiber converter.
`timescale 1ns/100ps

module sfr_router #(
  parameter int ACT_CYCLES = sfr_pkg::ACT_PULSE_CYC
) (
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire logic                      routing_select_switch,
  input  wire logic                      idle_level_switch,
  input  wire logic                      failover_switch,
  input  wire logic                      second_port_disable_switch,
  input  wire logic                      single_port_variant,
  input  wire logic                      copper_rxd,
  output logic                           copper_txd,
  input  wire logic                      opt_a_rx_light,
  input  wire logic                      opt_b_rx_light,
  output logic                           opt_a_tx_light,
  output logic                           opt_b_tx_light,
  input  wire logic [sfr_pkg::LVL_W-1:0] opt_a_level,
  input  wire logic [sfr_pkg::LVL_W-1:0] opt_b_level,
  input  wire logic                      bp_data_i,
  output logic                           bp_data_o,
  output logic                           bp_data_oe,
  output logic [sfr_pkg::BAR_W-1:0]      optical_quality_bar_a,
  output logic [sfr_pkg::BAR_W-1:0]      optical_quality_bar_b,
  output logic                           relay_energized,
  output logic                           copper_tx_activity_led,
  output logic                           copper_rx_activity_led,
  output logic                           port_b_selected
);
  import sfr_pkg::*;

  localparam logic [ACT_CNT_W-1:0] ACT_LOAD = ACT_CNT_W'(ACT_CYCLES);

  sfr_state_s st_r;
  sfr_state_s st_nxt;

  sfr_qual_e  qa;
  sfr_qual_e  qb;
  logic       a_rx;
  logic       b_rx;
  logic       rx_sel;
  logic       bp_others;
  logic       cu_tx_d;
  logic       a_tx_d;
  logic       b_tx_d;
  logic       bp_drv;

  // Bar segments for one port; in dark-idle mode only raw light is shown.
  function automatic logic [BAR_W-1:0] bar_of(input sfr_qual_e q,
                                              input logic      light,
                                              input logic      idle_light_off,
                                              input logic      en);
    if (!en)
      return BAR_OFF;
    if (idle_light_off)
      return light ? BAR_VGOOD : BAR_OFF;
    unique case (q)
      Q_VGOOD: return BAR_VGOOD;
      Q_GOOD:  return BAR_GOOD;
      Q_CRIT:  return BAR_CRIT;
      Q_ERR:   return BAR_ERR;
    endcase
  endfunction : bar_of

  always_comb begin
    st_nxt = st_r;
    qa     = sfr_quality(opt_a_level);
    qb     = sfr_quality(opt_b_level);
    // Light polarity: on at idle means light carries logic 1 directly.
    a_rx   = opt_a_rx_light ^ st_r.idle_light_off;
    b_rx   = st_r.bdis ? 1'b1 : (opt_b_rx_light ^ st_r.idle_light_off);
    rx_sel = st_r.use_b ? b_rx : a_rx;
    // Our own low drive on the wired backplane must not echo back.
    bp_others = bp_data_i | st_r.bp_oe;
    cu_tx_d   = 1'b1;
    a_tx_d    = 1'b1;
    b_tx_d    = 1'b1;
    bp_drv    = 1'b1;

    if (!st_r.cfg_done) begin
      // Straps are taken once, the first edge after reset release.
      st_nxt.cfg_done = 1'b1;
      st_nxt.star     = routing_select_switch;
      st_nxt.red      = failover_switch & ~single_port_variant;
      st_nxt.bdis     = second_port_disable_switch |
                        single_port_variant;
      st_nxt.idle_light_off     = idle_level_switch &
                        ~(failover_switch & ~single_port_variant);
    end else begin
      if (st_r.red) begin
        cu_tx_d = rx_sel & (st_r.star ? bp_data_i : 1'b1);
        a_tx_d  = copper_rxd & (st_r.star ? bp_others : 1'b1);
        b_tx_d  = a_tx_d;
        bp_drv  = copper_rxd & rx_sel;
      end else if (st_r.star) begin
        cu_tx_d = a_rx & b_rx & bp_data_i;
        a_tx_d  = copper_rxd & bp_others;
        b_tx_d  = a_tx_d;
        bp_drv  = copper_rxd & a_rx & b_rx;
      end else begin
        cu_tx_d = a_rx;
        a_tx_d  = copper_rxd & b_rx;
        b_tx_d  = a_rx;
      end

      st_nxt.use_b  = st_r.red & ~st_r.bdis & (qa <= Q_CRIT);
      st_nxt.cu_txd = cu_tx_d;
      st_nxt.a_tx   = a_tx_d ^ st_r.idle_light_off;
      st_nxt.b_tx   = st_r.bdis ? 1'b0 : (b_tx_d ^ st_r.idle_light_off);
      st_nxt.bp_o   = 1'b0;
      st_nxt.bp_oe  = st_r.star & ~bp_drv;
      st_nxt.bar_a  = bar_of(qa, opt_a_rx_light, st_r.idle_light_off, 1'b1);
      st_nxt.bar_b  = bar_of(qb, opt_b_rx_light, st_r.idle_light_off,
                             ~st_r.bdis);
      // Without steady idle light there is no power figure to judge.
      st_nxt.relay  = st_r.idle_light_off |
                      ((qa > Q_CRIT) &&
                       (st_r.bdis || (qb > Q_CRIT)));

      if (!cu_tx_d)
        st_nxt.tx_cnt = ACT_LOAD;
      else if (st_r.tx_cnt != '0)
        st_nxt.tx_cnt = st_r.tx_cnt - 1'b1;
      if (!copper_rxd)
        st_nxt.rx_cnt = ACT_LOAD;
      else if (st_r.rx_cnt != '0)
        st_nxt.rx_cnt = st_r.rx_cnt - 1'b1;
      st_nxt.led_tx = (st_nxt.tx_cnt != '0);
      st_nxt.led_rx = (st_nxt.rx_cnt != '0);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= SFR_STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign copper_txd             = st_r.cu_txd;
  assign opt_a_tx_light         = st_r.a_tx;
  assign opt_b_tx_light         = st_r.b_tx;
  assign bp_data_o              = st_r.bp_o;
  assign bp_data_oe             = st_r.bp_oe;
  assign optical_quality_bar_a  = st_r.bar_a;
  assign optical_quality_bar_b  = st_r.bar_b;
  assign relay_energized        = st_r.relay;
  assign copper_tx_activity_led = st_r.led_tx;
  assign copper_rx_activity_led = st_r.led_rx;
  assign port_b_selected        = st_r.use_b;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  logic line_on;
  logic star_on;
  assign line_on = st_r.cfg_done & ~st_r.star & ~st_r.red;
  assign star_on = st_r.cfg_done & st_r.star & ~st_r.red;

  property p_cfg_frozen;
    st_r.cfg_done |=> $stable({st_r.star, st_r.idle_light_off, st_r.red, st_r.bdis});
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen)
    else $error("configuration changed after power-up");

  property p_strap_take;
    !st_r.cfg_done ##1 st_r.cfg_done |->
      st_r.star == $past(routing_select_switch);
  endproperty
  a_strap_take: assert property (p_strap_take)
    else $error("routing mode not taken from its switch");

  property p_line_a_to_cu;
    line_on ##1 line_on |-> copper_txd == ($past(opt_a_rx_light) ^ st_r.idle_light_off);
  endproperty
  a_line_a_to_cu: assert property (p_line_a_to_cu)
    else $error("line routing lost port A to copper path");

  property p_line_a_to_b;
    line_on && !st_r.bdis ##1 line_on |->
      opt_b_tx_light == $past(opt_a_rx_light);
  endproperty
  a_line_a_to_b: assert property (p_line_a_to_b)
    else $error("line routing did not relay port A to port B");

  property p_line_no_bp;
    line_on ##1 line_on |-> !bp_data_oe;
  endproperty
  a_line_no_bp: assert property (p_line_no_bp)
    else $error("line routing drove the backplane");

  property p_star_cu_to_opt;
    star_on ##1 star_on |->
      opt_a_tx_light == ($past(copper_rxd & (bp_data_i | bp_data_oe))
                         ^ st_r.idle_light_off) && (opt_b_tx_light == opt_a_tx_light
                         || st_r.bdis);
  endproperty
  a_star_cu_to_opt: assert property (p_star_cu_to_opt)
    else $error("star routing copper to optical path wrong");

  property p_idle_red;
    st_r.cfg_done && st_r.red |-> !st_r.idle_light_off;
  endproperty
  a_idle_red: assert property (p_idle_red)
    else $error("redundancy without steady idle light");

  property p_single;
    st_r.cfg_done && $past(single_port_variant) && !$past(st_r.cfg_done)
      |-> st_r.bdis && !st_r.red;
  endproperty
  a_single: assert property (p_single)
    else $error("single-port variant honoured port B switches");

  property p_relay_drop;
    st_r.cfg_done && !st_r.idle_light_off && sfr_quality(opt_a_level) <= Q_CRIT
      |=> !relay_energized;
  endproperty
  a_relay_drop: assert property (p_relay_drop)
    else $error("relay held at critical power");

  property p_bar_crit;
    st_r.cfg_done && !st_r.idle_light_off && sfr_quality(opt_a_level) == Q_CRIT
      |=> optical_quality_bar_a == BAR_CRIT;
  endproperty
  a_bar_crit: assert property (p_bar_crit)
    else $error("critical level shown wrongly");

  property p_b_err;
    st_r.cfg_done && !st_r.idle_light_off && !st_r.bdis && !opt_b_level[LVL_FLOOR]
      |=> optical_quality_bar_b == BAR_ERR;
  endproperty
  a_b_err: assert property (p_b_err)
    else $error("dead port B not flagged red");

  property p_b_off;
    st_r.cfg_done && st_r.bdis |=> optical_quality_bar_b == BAR_OFF &&
                                   !opt_b_tx_light;
  endproperty
  a_b_off: assert property (p_b_off)
    else $error("disabled port B still active");

  property p_idle_light_off_bar;
    st_r.cfg_done && st_r.idle_light_off |=>
      optical_quality_bar_a == ($past(opt_a_rx_light) ? BAR_VGOOD : BAR_OFF);
  endproperty
  a_idle_light_off_bar: assert property (p_idle_light_off_bar)
    else $error("bar shows power evaluation in dark-idle mode");

  property p_rx_led;
    st_r.cfg_done && !copper_rxd |=> copper_rx_activity_led [*2];
  endproperty
  a_rx_led: assert property (p_rx_led)
    else $error("receive activity not indicated");

  // A space on the copper output reloads the counter at the same edge.
  property p_tx_led;
    st_r.cfg_done && !copper_txd |-> copper_tx_activity_led;
  endproperty
  a_tx_led: assert property (p_tx_led)
    else $error("transmit activity not indicated");

  property p_failover;
    st_r.cfg_done && st_r.red && !st_r.bdis &&
      sfr_quality(opt_a_level) <= Q_CRIT |=> port_b_selected;
  endproperty
  a_failover: assert property (p_failover)
    else $error("no failover to port B");

  c_star:     cover property (star_on && bp_data_oe);
  c_failover: cover property (!port_b_selected ##1 port_b_selected);
  c_relay:    cover property (relay_energized ##1 !relay_energized);
  c_idle_light_off:     cover property (st_r.cfg_done && st_r.idle_light_off && !copper_rxd);
  c_red_star: cover property (st_r.cfg_done && st_r.red && st_r.star &&
                              bp_data_oe);

endmodule : sfr_router

//--- testbench/sfr_far_end.sv
// Far-side model: serial terminal plus remote fiber converters.
`timescale 1ns/100ps

module sfr_far_end (
  input  wire logic clk,
  input  wire logic slow,
  input  wire logic idle_light_off,
  input  wire logic term_bit,
  input  wire logic a_bit,
  input  wire logic b_bit,
  output logic      copper_rxd,
  output logic      a_light,
  output logic      b_light
);
  logic ph_r = 1'h0;

  // A slow far end holds every bit for two cycles, as a low baud rate would.
  always @(negedge clk) begin
    ph_r <= ~ph_r;
    if (!slow || ph_r) begin
      copper_rxd <= term_bit;
      a_light    <= a_bit ^ idle_light_off;
      b_light    <= b_bit ^ idle_light_off;
    end
  end
endmodule : sfr_far_end

//--- testbench/sfr_router_test.sv
// Self-checking bench of the serial fiber port router.
`timescale 1ns/100ps

module sfr_router_test;
  import sfr_pkg::*;
  localparam int ACT = 8;
  localparam int N   = 200;
  // Switch rows: routing, idle level, failover, port B off, one-port strap.
  localparam logic [4:0] CFG [9] =
    '{5'h00, 5'h08, 5'h02, 5'h10, 5'h1a, 5'h0c, 5'h15, 5'h05,
      5'h1c};
  logic             clk  = 1'h0;
  logic             nrst = 1'h0;
  logic             s_rt = 1'h0, s_id = 1'h0, s_fo = 1'h0, s_bd = 1'h0;
  logic             s_sp = 1'h0, slow = 1'h0, bp_i = 1'h1, e_idle_light_off = 1'h0;
  logic             tb = 1'h1, ab = 1'h1, bb = 1'h1;
  logic [LVL_W-1:0] la = 3'h7, lb = 3'h7;
  logic             rxd, a_l, b_l, txd, a_tx, b_tx, bp_o, bp_oe;
  logic             relay, led_t, led_r, psel, chg;
  logic [BAR_W-1:0] bar_a, bar_b, e_bar_a, e_bar_b;
  logic             e_star, e_red, e_bdis, e_txd, e_a, e_b, e_oe, e_sel, e_rel;
  int               error_cnt = 0;
  int               comparisons = 0;
  int               ct, cr;

  initial begin
    forever #10 clk = ~clk;
  end

  sfr_router #(.ACT_CYCLES(ACT)) i_dut (
    .clk(clk), .nrst(nrst), .routing_select_switch(s_rt),
    .idle_level_switch(s_id), .failover_switch(s_fo),
    .second_port_disable_switch(s_bd), .single_port_variant(s_sp),
    .copper_rxd(rxd), .copper_txd(txd), .opt_a_rx_light(a_l),
    .opt_b_rx_light(b_l), .opt_a_tx_light(a_tx), .opt_b_tx_light(b_tx),
    .opt_a_level(la), .opt_b_level(lb), .bp_data_i(bp_i),
    .bp_data_o(bp_o), .bp_data_oe(bp_oe), .optical_quality_bar_a(bar_a),
    .optical_quality_bar_b(bar_b), .relay_energized(relay),
    .copper_tx_activity_led(led_t), .copper_rx_activity_led(led_r),
    .port_b_selected(psel));

  sfr_far_end i_far (.clk(clk), .slow(slow), .idle_light_off(e_idle_light_off), .term_bit(tb),
    .a_bit(ab), .b_bit(bb), .copper_rxd(rxd), .a_light(a_l), .b_light(b_l));

  task automatic give_verdict();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic logic [BAR_W-1:0] bar_of(input logic [LVL_W-1:0] l);
    if (!l[0]) return BAR_ERR;
    if (!l[1]) return BAR_CRIT;
    if (!l[2]) return BAR_GOOD;
    return BAR_VGOOD;
  endfunction : bar_of

  // Works out the outputs of the next edge from the inputs now settled.
  task automatic predict();
    logic ra, rb, rs, oe_p;
    ra    = a_l ^ e_idle_light_off;
    rb    = e_bdis | (b_l ^ e_idle_light_off);
    // Received data follows the port choice registered at the last edge.
    rs    = e_sel ? rb : ra;
    oe_p  = e_oe;
    e_sel = e_red & ~e_bdis & ~(la[0] & la[1]);
    e_txd = e_red ? rs : (e_star ? ra & rb : ra);
    if (e_star) e_txd = e_txd & bp_i;
    e_a   = rxd & (e_star ? (bp_i | oe_p) : (e_red | rb));
    e_oe  = e_star & ~(rxd & (e_red ? rs : ra & rb));
    e_b = (e_star | e_red) ? e_a : ra;
    e_a = e_a ^ e_idle_light_off;
    e_b = e_bdis ? 1'h0 : e_b ^ e_idle_light_off;
    // With dark idle the bar only mirrors the received light.
    e_bar_a = e_idle_light_off ? (a_l ? BAR_VGOOD : BAR_OFF) : bar_of(la);
    e_bar_b = e_bdis ? BAR_OFF : e_idle_light_off ? (b_l ? BAR_VGOOD : BAR_OFF)
                                        : bar_of(lb);
    e_rel = e_idle_light_off | (la[0] & la[1] & (e_bdis | (lb[0] & lb[1])));
    cr = !rxd ? ACT : (cr != 0 ? cr - 1 : 0);
    ct = !e_txd ? ACT : (ct != 0 ? ct - 1 : 0);
  endtask : predict

  initial begin
    void'($urandom(81));
    for (int r = 0; r < 9; r++) begin
      @(negedge clk);
      nrst <= 1'h0;
      {s_rt, s_id, s_fo, s_bd, s_sp} <= CFG[r];
      e_star = CFG[r][4];
      e_red  = CFG[r][2] & ~CFG[r][0];
      e_idle_light_off = CFG[r][3] & ~e_red;
      e_bdis = CFG[r][1] | CFG[r][0];
      slow  <= r[0];
      e_oe   = 1'h0;
      e_sel  = 1'h0;
      ct     = 0;
      cr     = 0;
      repeat (6) @(negedge clk);
      chk("reset_bits", 8'h80,
          {txd, a_tx, b_tx, bp_o, bp_oe, relay, led_t, led_r});
      chk("reset_bars", 8'h00, {bar_a, bar_b});
      nrst <= 1'h1;
      for (int i = 0; i <= N; i++) begin
        @(negedge clk);
        if (i > 0) begin
          chk("copper_txd", e_txd, txd);
          chk("opt_a_tx", e_a, a_tx);
          chk("opt_b_tx", e_b, b_tx);
          chk("bp_oe", e_oe, bp_oe);
          chk("bp_o", 8'h00, bp_o);
          chk("bar_a", e_bar_a, bar_a);
          chk("bar_b", e_bar_b, bar_b);
          chk("relay", e_rel, relay);
          chk("port_b_sel", e_sel, psel);
          chk("rx_led", cr != 0, led_r);
          chk("tx_led", ct != 0, led_t);
        end
        tb   <= ($urandom % 4) != 0;
        ab   <= ($urandom % 4) != 0;
        bb   <= ($urandom % 4) != 0;
        bp_i <= ($urandom % 4) != 0;
        {s_rt, s_id, s_fo, s_bd} <= 4'($urandom);
        chg = ($urandom % 8) == 0;
        if (chg) {la, lb} <= 6'($urandom);
        #1;
        predict();
      end
    end
    give_verdict();
  end

  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
endmodule : sfr_router_test
